// ---- verilog/prox_diode_select_config.sv ----
// photodiode selection register, pair combining and sleep-after-irq
`timescale 1ns/1ns
`include "prox_diode_params.svh"
module prox_diode_select_config (
    input wire logic sys_clk, // 20 MHz device clock
    input wire logic rst, // async reset, active high
    input wire prox_diode_pkg::reg_req_t regReq, // register access
    input wire prox_diode_pkg::diode_samples_t samples, // diode levels
    input wire logic irqAsserted, // interrupt pin is asserted
    input wire logic sleepPoint, // sequencer at sleep decision
    input wire logic irqClear, // host cleared interrupt over bus
    output logic [7:0] rdData, // register read data
    output logic [8:0] proxResult, // combined proximity value
    output logic sleeping // device held in low power
);
    import prox_diode_pkg::*;

    // the selection register steers which diodes reach the result, the doubling and sleep-after-irq;
    // the converter, offsets and interrupt status live in other blocks
    // result is registered so downstream logic never sees a mask change
    // glitch through the adders in the middle of a cycle
    // reserved bits are stored as written rather than forced to zero,
    // so a host that breaks the reserved-bit rule reads back its mistake
    // sleep state is mirrored into its own flop so the output pin is a
    // clean register and not a decode of the state encoding

    logic [7:0] cfg_r, cfg_nxt; // selection register
    logic [7:0] rdData_r, rdData_nxt; // read data holder
    logic [8:0] prox_r, prox_nxt; // combined result
    pwr_state_t pwr_r, pwr_nxt; // power state
    logic sleep_r, sleep_nxt; // registered copy of sleep state
    logic [7:0] gateN, gateS, gateW, gateE; // masked diode levels
    logic [7:0] pairNE, pairSW; // per pair sums
    logic [8:0] raw; // pair total before gain
    logic halfPairs; // at most one diode left in each pair

    // one gate per diode; a set mask bit drops it
    diode_gate gateNorth (
        .level(samples.north), // north level
        .masked(cfg_r[`BIT_MASK_N]), // north mask
        .gated(gateN) // north after mask
    );
    diode_gate gateSouth (
        .level(samples.south), // south level
        .masked(cfg_r[`BIT_MASK_S]), // south mask
        .gated(gateS) // south after mask
    );
    diode_gate gateWest (
        .level(samples.west), // west level
        .masked(cfg_r[`BIT_MASK_W]), // west mask
        .gated(gateW) // west after mask
    );
    diode_gate gateEast (
        .level(samples.east), // east level
        .masked(cfg_r[`BIT_MASK_E]), // east mask
        .gated(gateE) // east after mask
    );

    // pattern flag used only by the scale checks below
    assign halfPairs =
        (cfg_r[`BIT_MASK_N] | cfg_r[`BIT_MASK_E])
        & (cfg_r[`BIT_MASK_S] | cfg_r[`BIT_MASK_W]);

    // register write and readback
    always_comb
    begin
        cfg_nxt = cfg_r;
        rdData_nxt = rdData_r;
        if (regReq.wrEn && regReq.addr == `DIODE_SEL_ADDR)
        begin
            // reserved bits stored as written; host keeps them zero
            cfg_nxt = regReq.wdata;
        end
        if (regReq.rdEn && regReq.addr == `DIODE_SEL_ADDR)
            rdData_nxt = cfg_r;
        else if (regReq.rdEn)
            rdData_nxt = 8'h00; // other addresses live elsewhere
    end

    // pair combining with masking and optional doubling
    always_comb
    begin
        // each diode contributes half of its pair's range
        pairNE = gateN + gateE;
        pairSW = gateS + gateW;
        // pairs averaged so both full pairs reach 254, one diode per pair 127
        raw = {1'b0, pairNE} + {1'b0, pairSW};
        raw = {1'b0, raw[8:1]};
        prox_nxt = raw;
        if (cfg_r[`BIT_GAIN_COMP])
        begin
            // doubling, clipped at full scale
            prox_nxt = {raw[7:0], 1'b0};
            if (raw > `HALF_SCALE)
                prox_nxt = `FULL_SCALE;
        end
    end

    // sleep after interrupt sequencing
    always_comb
    begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            PWR_RUN:
                if (cfg_r[`BIT_SLEEP_IRQ] && irqAsserted && sleepPoint)
                    pwr_nxt = PWR_SLEEP;
            PWR_SLEEP:
                if (irqClear)
                    pwr_nxt = PWR_RUN;
        endcase
        // output flop follows the next state, no extra latency
        sleep_nxt = (pwr_nxt == PWR_SLEEP);
    end

    // all state registered here
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_r <= `DIODE_SEL_RESET;
            rdData_r <= 8'h00;
            prox_r <= 9'h000;
            pwr_r <= PWR_RUN;
            sleep_r <= 1'b0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            rdData_r <= rdData_nxt;
            prox_r <= prox_nxt;
            pwr_r <= pwr_nxt;
            sleep_r <= sleep_nxt;
        end
    end

    assign rdData = rdData_r;
    assign proxResult = prox_r;
    assign sleeping = sleep_r;

    // the two steps of a sleep cycle
    sequence sleepCause_s;
        !sleeping && cfg_r[`BIT_SLEEP_IRQ] && irqAsserted && sleepPoint;
    endsequence
    sequence wakeCause_s;
        sleeping && irqClear;
    endsequence

    // write lands in register next cycle
    cfg_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        regReq.wrEn && regReq.addr == `DIODE_SEL_ADDR
        |=> cfg_r == $past(regReq.wdata))
        else $error("selection register missed write");
    // result never exceeds full scale
    result_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
        proxResult <= `FULL_SCALE)
        else $error("proximity result above full scale");
    // uncompensated with one diode per pair stays at half scale
    nocomp_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(cfg_r[`BIT_GAIN_COMP]) && $past(halfPairs)
        |-> proxResult <= `HALF_SCALE)
        else $error("uncompensated result too large");
    // compensated result is doubled or clipped
    comp_even_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(cfg_r[`BIT_GAIN_COMP]) |-> !proxResult[0] || proxResult == `FULL_SCALE)
        else $error("compensated result not doubled");
    // read of the register returns its contents
    readback_a: assert property (@(posedge sys_clk) disable iff (rst)
        regReq.rdEn && regReq.addr == `DIODE_SEL_ADDR |=> rdData == $past(cfg_r))
        else $error("readback differs from register");
    // other addresses read as zero
    unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
        regReq.rdEn && regReq.addr != `DIODE_SEL_ADDR |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    // read data holds between reads
    rd_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !regReq.rdEn |=> $stable(rdData))
        else $error("read data changed without read");
    // register changes only on its own write
    cfg_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !(regReq.wrEn && regReq.addr == `DIODE_SEL_ADDR) |=> $stable(cfg_r))
        else $error("selection register changed unasked");
    // never sleeps with the option off
    no_option_a: assert property (@(posedge sys_clk) disable iff (rst)
        !cfg_r[`BIT_SLEEP_IRQ] && !sleeping |=> !sleeping)
        else $error("slept with option off");
    // all masked gives zero
    masked_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_r[3:0] == 4'hF |=> proxResult == 9'h000)
        else $error("fully masked result not zero");
    // sleep entry on its three conditions
    sleep_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
        sleepCause_s |=> sleeping)
        else $error("did not sleep after interrupt");
    // no sleep without the option
    sleep_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(sleeping)
        |-> $past(cfg_r[`BIT_SLEEP_IRQ] && irqAsserted && sleepPoint))
        else $error("slept without cause");
    // stays asleep until cleared
    sleep_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        sleeping && !irqClear |=> sleeping)
        else $error("woke without interrupt clear");
    // clear wakes
    sleep_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
        wakeCause_s |=> !sleeping)
        else $error("stayed asleep after clear");
endmodule

// single diode gate: passes the level or zero when masked
module diode_gate (
    input wire logic [6:0] level, // diode level
    input wire logic masked, // mask bit, high drops the diode
    output logic [7:0] gated // level widened for pair sums
);
    import prox_diode_pkg::*;
    // widened by one bit so two gates add without overflow
    assign gated = masked ? 8'h00 : {1'b0, level};
endmodule

// ---- verilog/prox_diode_params.svh ----
// constants for the proximity photodiode selection block
// Functional notes
// - north/east form one pair, south/west other
// - one mask bit per diode, set removes it
// - bit 5 set applies extra gain of two
// - one diode per pair saturates 127, compensated reaches 254
// - bit 4 sleeps after interrupt at decision point
// - wake only after host clears pending interrupt
`ifndef PROX_DIODE_PARAMS_SVH
`define PROX_DIODE_PARAMS_SVH
`define DIODE_SEL_ADDR 8'h9F
`define DIODE_SEL_RESET 8'h00
`define BIT_GAIN_COMP 5
`define BIT_SLEEP_IRQ 4
`define BIT_MASK_N 3
`define BIT_MASK_S 2
`define BIT_MASK_W 1
`define BIT_MASK_E 0
`define HALF_SCALE 9'h07F
`define FULL_SCALE 9'h0FF
`endif

// ---- verilog/prox_diode_pkg.sv ----
// types for the proximity photodiode selection block
package prox_diode_pkg;
    // register access from the serial bus engine
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    // raw samples of the four diodes
    typedef struct packed {
        logic [6:0] north;
        logic [6:0] south;
        logic [6:0] west;
        logic [6:0] east;
    } diode_samples_t;
    // sequencer power state
    typedef enum logic {PWR_RUN, PWR_SLEEP} pwr_state_t;
endpackage

// ---- verification/host_model.sv ----
// host model issuing register bus accesses
`timescale 1ns/1ns
module host_model (
    input wire logic sys_clk, // device clock
    input wire logic [7:0] rdData, // read data from device
    output prox_diode_pkg::reg_req_t regReq, // bus request
    output logic irqClear, // interrupt clear pulse
    output logic [7:0] rdVal // last value read
);
    import prox_diode_pkg::*;
    initial
    begin
        regReq = '0;
        irqClear = 1'b0;
        rdVal = 8'h00;
    end
    // one access, held for exactly one sampling edge
    task automatic access(input logic wr, input logic [7:0] a,
        input logic [7:0] d);
        @(negedge sys_clk);
        regReq = '{wrEn: wr, rdEn: !wr, addr: a, wdata: d};
        @(negedge sys_clk);
        regReq = '0;
        rdVal = rdData;
    endtask
    // gain bit chosen from mask pattern, reserved bits kept zero
    task automatic set_cfg(input logic slp, input logic [3:0] m,
        output logic [7:0] v);
        logic comp;
        comp = m inside {4'h7, 4'hB, 4'hE, 4'hD, 4'h6, 4'h9};
        v = {2'b00, comp, slp, m};
        access(1'b1, 8'h9F, v);
    endtask
    // clear pending interrupt over the bus
    task automatic clear_irq;
        @(negedge sys_clk);
        irqClear = 1'b1;
        @(negedge sys_clk);
        irqClear = 1'b0;
    endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the photodiode selection block
`timescale 1ns/1ns
module tb;
    import prox_diode_pkg::*;
    logic sys_clk = 1'b0; // 20 MHz clock
    logic rst = 1'b1; // reset
    logic irqAsserted = 1'b0; // interrupt pin
    logic sleepPoint = 1'b0; // sequencer decision
    reg_req_t regReq; // bus request
    logic irqClear; // clear pulse
    logic [7:0] rdData, rdVal, v;
    logic [8:0] proxResult;
    logic sleeping;
    int numErrors = 0;
    int totalChecks = 0;
    int cycles = 0;
    // distinct levels so a swapped mask bit shows
    diode_samples_t samples = '{7'h7F, 7'h11, 7'h22, 7'h44};
    always #25 sys_clk = !sys_clk;
    host_model host (.sys_clk(sys_clk), .rdData(rdData),
        .regReq(regReq), .irqClear(irqClear), .rdVal(rdVal));
    prox_diode_select_config uut (.sys_clk(sys_clk), .rst(rst),
        .regReq(regReq), .samples(samples), .irqAsserted(irqAsserted),
        .sleepPoint(sleepPoint), .irqClear(irqClear), .rdData(rdData),
        .proxResult(proxResult), .sleeping(sleeping));
    // masked pair sums averaged, doubled and clipped when compensated
    function automatic logic [8:0] exp_res(input logic [7:0] c);
        logic [9:0] s;
        s = {3'b0, samples.north & {7{!c[3]}}}
            + {3'b0, samples.east & {7{!c[0]}}}
            + {3'b0, samples.south & {7{!c[2]}}}
            + {3'b0, samples.west & {7{!c[1]}}};
        s = s >> 1;
        if (c[5])
            s = s << 1;
        return (s > 10'h0FF) ? 9'h0FF : s[8:0];
    endfunction
    task automatic check(input string nm, input logic [8:0] e,
        input logic [8:0] g);
        totalChecks++;
        if (g !== e)
        begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard, tests need well under 400 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            numErrors++;
            finish_test();
        end
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) rst = 1'b0;
        host.access(1'b0, 8'h9F, 8'h00);
        check("reset", 9'h000, {1'b0, rdVal});
        for (int i = 0; i < 16; i++)
        begin
            host.set_cfg(1'b0, 4'(i), v);
            @(negedge sys_clk);
            check("result", exp_res(v), proxResult);
            host.access(1'b0, 8'h9F, 8'h00);
            check("readback", {1'b0, v}, {1'b0, rdVal});
        end
        // unmapped address: write ignored, read zero
        host.access(1'b1, 8'h9E, 8'hFF);
        host.access(1'b0, 8'h9E, 8'h00);
        check("unmapped", 9'h000, {1'b0, rdVal});
        host.access(1'b0, 8'h9F, 8'h00);
        check("kept", {1'b0, v}, {1'b0, rdVal});
        irqAsserted = 1'b1;
        sleepPoint = 1'b1;
        @(negedge sys_clk);
        check("no sleep", 9'h000, {8'h00, sleeping});
        host.set_cfg(1'b1, 4'h0, v);
        @(negedge sys_clk);
        check("sleep", 9'h001, {8'h00, sleeping});
        sleepPoint = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("held", 9'h001, {8'h00, sleeping});
        irqAsserted = 1'b0;
        host.clear_irq();
        check("wake", 9'h000, {8'h00, sleeping});
        finish_test();
    end
endmodule
